// >>> rtl/prmc_ctrl.sv
// Purpose: Idle and Power Down sequencing
// Assumes: irq_pending only covers sources enabled before entry
// Notes: reset input is the hardware reset, active high
//
// Operation
// R1 - Idle after instruction and predecessor complete
// R2 - Idle instruction is protected 32-bit word
// R3 - Idle halts CPU only, peripherals run
// R4 - Finish pending external bus actions first; code does not wait, bus_busy refuses entry back to prmc_run
// R5 - Refuse entry if ready unused last access
// R6 - Any reset or enabled request ends Idle
// R7 - Serviceable interrupt: service, resume after Idle
// R8 - Unserviceable interrupt: resume immediately, no Idle
// R9 - Serviceable event transfer: transfer, stay Idle
// R10 - Unserviceable event transfer ends Idle
// R11 - NMI falling edge ends Idle, enters trap
// R12 - Level zero wakes without vector fetch
// R13 - Watchdog overflow in Idle gives reset
// R14 - Power Down stops all clocking, RAM kept
// R15 - Only hardware reset leaves Power Down
// R16 - Power down instruction protected 32-bit word
// R17 - Power down only with NMI pin low
// R18 - Power Down after instruction completes
// R19 - Halt and clock gate separate outputs
`include "prmc_defs.svh"
module prmc_ctrl (
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] instr_word,
    input wire logic instr_valid,
    input wire logic prev_instr_done,
    input wire logic bus_busy,
    input wire logic ready_enabled,
    input wire logic ready_seen_low,
    input wire logic irq_pending,
    input wire logic irq_is_event_xfer,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] cpu_level,
    input wire logic global_interrupt_enable,
    input wire logic nmi_pin,
    input wire logic watchdog_overflow,
    input wire logic xfer_done,
    output logic cpu_halt,
    output logic periph_clock_gate,
    output logic resume_pulse,
    output logic service_irq,
    output logic fetch_vector,
    output logic start_event_xfer,
    output logic nmi_trap,
    output logic internal_reset,
    output logic idle_active,
    output logic down_active
);
    import prmc_pkg::*;

    // ----------------------------------------
    // Decode and wake classification
    // ----------------------------------------
    prmc_cmd_type cmd;
    logic serviceable;
    logic vector_ok;
    prmc_state_type state_q;
    prmc_state_type state_d;
    logic nmi_q;
    logic nmi_fall;
    logic entry_ok;

    prmc_decode u_decode (
        .instr_word(instr_word),
        .instr_valid(instr_valid),
        .cmd(cmd)
    );

    prmc_wake u_wake (
        .irq_pending(irq_pending),
        .irq_is_event_xfer(irq_is_event_xfer),
        .irq_level(irq_level),
        .cpu_level(cpu_level),
        .global_interrupt_enable(global_interrupt_enable),
        .serviceable(serviceable),
        .vector_fetch(vector_ok)
    );

    // ----------------------------------------
    // NMI edge detection
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            nmi_q <= 1'b1;
        end else begin
            nmi_q <= nmi_pin;
        end
    end

    assign nmi_fall = nmi_q && !nmi_pin; // see R11

    // Bus idle and ready handshake used before entry
    assign entry_ok = !bus_busy // see R4
        && !(ready_enabled && !ready_seen_low); // see R5

    // ----------------------------------------
    // State machine
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            prmc_run: begin
                if (cmd == prmc_cmd_idle) begin
                    state_d = prmc_idle_wait;
                end else if (cmd == prmc_cmd_down && !nmi_pin) begin
                    state_d = prmc_down_wait; // see R17
                end
            end
            prmc_idle_wait: begin
                if (!entry_ok) begin
                    state_d = prmc_run; // see R5
                end else if (prev_instr_done) begin
                    state_d = prmc_idle; // see R1
                end
            end
            prmc_idle: begin
                if (watchdog_overflow) begin
                    state_d = prmc_run; // see R13
                end else if (nmi_fall) begin
                    state_d = prmc_run; // see R11
                end else if (irq_pending) begin
                    if (irq_is_event_xfer && serviceable) begin
                        state_d = prmc_event_xfer; // see R9
                    end else begin
                        state_d = prmc_run; // see R6 see R8 see R10
                    end
                end
            end
            prmc_event_xfer: begin
                if (xfer_done) begin
                    state_d = prmc_idle; // see R9
                end
            end
            prmc_down_wait: begin
                if (!entry_ok) begin
                    state_d = prmc_run; // see R5
                end else if (prev_instr_done) begin
                    state_d = prmc_down; // see R18
                end
            end
            prmc_down: begin
                state_d = prmc_down; // see R15
            end
            default: begin
                state_d = prmc_run;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= prmc_run; // see R6 see R15
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // Event outputs
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            resume_pulse <= 1'b0;
            service_irq <= 1'b0;
            fetch_vector <= 1'b0;
            start_event_xfer <= 1'b0;
            nmi_trap <= 1'b0;
            internal_reset <= 1'b0;
        end else begin
            resume_pulse <= 1'b0;
            service_irq <= 1'b0;
            fetch_vector <= 1'b0;
            start_event_xfer <= 1'b0;
            nmi_trap <= 1'b0;
            internal_reset <= 1'b0;
            if (state_q == prmc_idle) begin
                if (watchdog_overflow) begin
                    internal_reset <= 1'b1; // see R13
                end else if (nmi_fall) begin
                    nmi_trap <= 1'b1; // see R11
                    resume_pulse <= 1'b1;
                end else if (irq_pending) begin
                    if (irq_is_event_xfer && serviceable) begin
                        start_event_xfer <= 1'b1; // see R9
                    end else begin
                        resume_pulse <= 1'b1; // see R8 see R10
                        service_irq <= serviceable && !irq_is_event_xfer;
                        fetch_vector <= vector_ok; // see R7 see R12
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Halt and clock gate
    // ----------------------------------------
    always_comb begin
        idle_active = (state_q == prmc_idle) // see R3
            || (state_q == prmc_event_xfer);
        down_active = (state_q == prmc_down);
        cpu_halt = idle_active || down_active; // see R19
        periph_clock_gate = down_active; // see R14 see R19
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    idle_needs_bus_a: assert property (@(posedge clock) disable iff (reset) // see R4
        (state_q == prmc_idle_wait && state_d == prmc_idle) |-> !bus_busy)
        else $error("idle entered with bus busy");

    ready_refuse_a: assert property (@(posedge clock) disable iff (reset) // see R5
        (state_q == prmc_idle_wait && ready_enabled && !ready_seen_low)
        |=> state_q == prmc_run)
        else $error("entry not refused without ready");

    down_needs_nmi_a: assert property (@(posedge clock) disable iff (reset) // see R17
        (state_q == prmc_run && cmd == prmc_cmd_down && nmi_pin)
        |=> state_q == prmc_run)
        else $error("power down without nmi low");

    down_sticky_a: assert property (@(posedge clock) disable iff (reset) // see R15
        down_active |=> down_active && periph_clock_gate)
        else $error("power down left without reset");

    idle_gate_off_a: assert property (@(posedge clock) disable iff (reset) // see R3
        idle_active |-> cpu_halt && !periph_clock_gate)
        else $error("idle gated peripherals");

    nmi_trap_a: assert property (@(posedge clock) disable iff (reset) // see R11
        (state_q == prmc_idle && nmi_fall && !watchdog_overflow)
        |=> nmi_trap && state_q == prmc_run)
        else $error("nmi did not end idle");

    wdt_reset_a: assert property (@(posedge clock) disable iff (reset) // see R13
        (state_q == prmc_idle && watchdog_overflow) |=> internal_reset)
        else $error("watchdog overflow missed");

    xfer_stay_a: assert property (@(posedge clock) disable iff (reset) // see R9
        (state_q == prmc_event_xfer && xfer_done) |=> state_q == prmc_idle)
        else $error("not back in idle after transfer");

    lvl0_no_vec_a: assert property (@(posedge clock) disable iff (reset) // see R12
        (state_q == prmc_idle && irq_pending && irq_level == `PRMC_LEVEL_ZERO
        && !nmi_fall && !watchdog_overflow)
        |=> !fetch_vector && resume_pulse)
        else $error("level zero fetched vector");

    low_prio_a: assert property (@(posedge clock) disable iff (reset) // see R8
        (state_q == prmc_idle && irq_pending && !serviceable
        && !nmi_fall && !watchdog_overflow)
        |=> state_q == prmc_run ##1 !idle_active)
        else $error("unserviceable request kept idle");

    idle_cmd_a: assert property ( // see R1
        @(posedge clock) disable iff (reset)
        (state_q == prmc_run && instr_valid
        && instr_word == `PRMC_IDLE_OPCODE) |=> state_q == prmc_idle_wait)
        else $error("idle instruction not taken");

    bad_word_a: assert property ( // see R2 see R16
        @(posedge clock) disable iff (reset)
        (state_q == prmc_run && instr_word != `PRMC_IDLE_OPCODE
        && instr_word != `PRMC_POWER_DOWN_INSTRUCTION_OPCODE) |=> state_q == prmc_run)
        else $error("unprotected word left run");

    idle_entry_a: assert property ( // see R1
        @(posedge clock) disable iff (reset)
        (state_q == prmc_idle_wait && entry_ok && prev_instr_done)
        |=> state_q == prmc_idle)
        else $error("idle not entered");

    wait_hold_a: assert property ( // see R1
        @(posedge clock) disable iff (reset)
        (state_q == prmc_idle_wait && entry_ok && !prev_instr_done)
        |=> state_q == prmc_idle_wait && !cpu_halt)
        else $error("idle before predecessor done");

    down_cmd_a: assert property ( // see R17
        @(posedge clock) disable iff (reset)
        (state_q == prmc_run && instr_valid && !nmi_pin
        && instr_word == `PRMC_POWER_DOWN_INSTRUCTION_OPCODE) |=> state_q == prmc_down_wait)
        else $error("power down instruction not taken");

    down_refuse_a: assert property ( // see R4 see R5
        @(posedge clock) disable iff (reset)
        (state_q == prmc_down_wait && !entry_ok) |=> state_q == prmc_run)
        else $error("power down not refused");

    down_entry_a: assert property ( // see R18
        @(posedge clock) disable iff (reset)
        (state_q == prmc_down_wait && entry_ok && prev_instr_done)
        |=> down_active)
        else $error("power down not entered");

    down_early_a: assert property ( // see R18
        @(posedge clock) disable iff (reset)
        (state_q == prmc_down_wait && !prev_instr_done) |=> !down_active)
        else $error("power down before completion");

    serv_irq_a: assert property ( // see R7
        @(posedge clock) disable iff (reset)
        (state_q == prmc_idle && irq_pending && !irq_is_event_xfer
        && serviceable && !nmi_fall && !watchdog_overflow)
        |=> service_irq && resume_pulse && state_q == prmc_run)
        else $error("serviceable interrupt not serviced");

    xfer_start_a: assert property ( // see R9
        @(posedge clock) disable iff (reset)
        (state_q == prmc_idle && irq_pending && irq_is_event_xfer
        && serviceable && !nmi_fall && !watchdog_overflow)
        |=> start_event_xfer && idle_active && !resume_pulse)
        else $error("event transfer not started");

    xfer_halt_a: assert property ( // see R9
        @(posedge clock) disable iff (reset)
        state_q == prmc_event_xfer |-> cpu_halt && !periph_clock_gate)
        else $error("cpu ran during transfer");

    down_gate_a: assert property ( // see R14
        @(posedge clock) disable iff (reset)
        down_active |-> cpu_halt && periph_clock_gate)
        else $error("power down left clocks running");

    gate_only_down_a: assert property ( // see R19
        @(posedge clock) disable iff (reset)
        periph_clock_gate |-> down_active)
        else $error("clock gated outside power down");

    down_quiet_a: assert property ( // see R15
        @(posedge clock) disable iff (reset)
        down_active |=> !resume_pulse && !internal_reset && !nmi_trap)
        else $error("wake event in power down");

    reset_run_a: assert property ( // see R6 see R15
        @(posedge clock)
        reset |=> state_q == prmc_run && !cpu_halt)
        else $error("reset did not return to run");
endmodule

// >>> rtl/prmc_defs.svh
// Purpose: constants for the power reduction mode controller
// Assumes: one 50 MHz clock
// Notes: encodings of the protected instruction words are arbitrary
`ifndef PRMC_DEFS_SVH
`define PRMC_DEFS_SVH
`define PRMC_IDLE_OPCODE 32'h87788778
`define PRMC_POWER_DOWN_INSTRUCTION_OPCODE 32'h97689768
`define PRMC_LEVEL_W 4
`define PRMC_LEVEL_ZERO 4'h0
`endif

// >>> rtl/prmc_pkg.sv
// Purpose: types for the power reduction mode controller
// Assumes: prmc_defs.svh constants
// Notes: none
package prmc_pkg;
    typedef enum logic [2:0] {
        prmc_run = 3'b000,
        prmc_idle_wait = 3'b001,
        prmc_idle = 3'b010,
        prmc_event_xfer = 3'b011,
        prmc_down_wait = 3'b100,
        prmc_down = 3'b101
    } prmc_state_type;
    typedef enum logic [1:0] {
        prmc_cmd_none = 2'b00,
        prmc_cmd_idle = 2'b01,
        prmc_cmd_down = 2'b10
    } prmc_cmd_type;
endpackage

// >>> rtl/prmc_decode.sv
// Purpose: recognises the protected power instructions
// Assumes: the full 32-bit word must match
// Notes: a partial match yields no command
`include "prmc_defs.svh"
module prmc_decode (
    input wire logic [31:0] instr_word,
    input wire logic instr_valid,
    output prmc_pkg::prmc_cmd_type cmd
);
    import prmc_pkg::*;
    always_comb begin
        cmd = prmc_cmd_none;
        if (instr_valid && instr_word == `PRMC_IDLE_OPCODE) begin // see R2
            cmd = prmc_cmd_idle;
        end else if (instr_valid && instr_word == `PRMC_POWER_DOWN_INSTRUCTION_OPCODE) begin
            cmd = prmc_cmd_down; // see R16
        end
    end
endmodule

// >>> rtl/prmc_wake.sv
// Purpose: classifies a wake request while in Idle
// Assumes: inputs synchronous to clock
// Notes: serviceable means level above CPU level and global enable
`include "prmc_defs.svh"
module prmc_wake (
    input wire logic irq_pending,
    input wire logic irq_is_event_xfer,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] cpu_level,
    input wire logic global_interrupt_enable,
    output logic serviceable,
    output logic vector_fetch
);
    always_comb begin
        serviceable = irq_pending && global_interrupt_enable
            && (irq_level > cpu_level); // see R7 see R9
        // Level zero wakes but never fetches a vector
        vector_fetch = serviceable && !irq_is_event_xfer
            && (irq_level != `PRMC_LEVEL_ZERO); // see R12
    end
endmodule

// >>> verif/prmc_xfer_model.sv
// Purpose: event transfer engine seen from the controller
// Assumes: start_event_xfer is a one-cycle pulse
// Notes: delay sets how slowly the transfer completes
module prmc_xfer_model (
    input wire logic clock,
    input wire logic start_event_xfer,
    input wire logic [3:0] delay,
    output logic xfer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int count = -1;
    initial xfer_done = 1'h0;
    // ----------------------------------------
    // Transfer timing
    // ----------------------------------------
    always @(negedge clock) begin
        xfer_done <= 1'h0;
        if (start_event_xfer) begin
            count <= int'(delay);
        end else if (count > 0) begin
            count <= count - 1;
        end else if (count == 0) begin
            xfer_done <= 1'h1;
            count <= -1;
        end
    end
endmodule

// >>> verif/test_power_reduction_mode_control.sv
// Purpose: self-checking bench for the power reduction controller
// Assumes: inputs change on the falling clock edge
// Notes: pulse outputs are gathered into a sticky mask
`include "prmc_defs.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module test_power_reduction_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, reset = 1'h1, instr_valid = 1'h0;
    logic [31:0] instr_word = 32'h0;
    logic prev_instr_done = 1'h1, bus_busy = 1'h0, ready_enabled = 1'h0;
    logic ready_seen_low = 1'h0, irq_pending = 1'h0, irq_is_event_xfer = 1'h0;
    logic global_interrupt_enable = 1'h0, nmi_pin = 1'h1, xfer_done;
    logic watchdog_overflow = 1'h0;
    logic [3:0] irq_level = 4'h0, cpu_level = 4'h2, xfer_delay = 4'h0;
    logic cpu_halt, periph_clock_gate, resume_pulse, service_irq;
    logic fetch_vector, start_event_xfer, nmi_trap, internal_reset;
    logic idle_active, down_active;
    logic [5:0] seen = 6'h00;
    int failures = 0, checks = 0;
    prmc_ctrl dut (.clock, .reset, .instr_word, .instr_valid,
        .prev_instr_done, .bus_busy, .ready_enabled, .ready_seen_low,
        .irq_pending, .irq_is_event_xfer, .irq_level, .cpu_level,
        .global_interrupt_enable, .nmi_pin, .watchdog_overflow, .xfer_done,
        .cpu_halt, .periph_clock_gate, .resume_pulse, .service_irq,
        .fetch_vector, .start_event_xfer, .nmi_trap, .internal_reset,
        .idle_active, .down_active);
    prmc_xfer_model partner (.clock, .start_event_xfer,
        .delay(xfer_delay), .xfer_done);
    // ----------------------------------------
    // Clock, pulse capture, watchdog
    // ----------------------------------------
    initial forever #10 clock = ~clock;
    always @(posedge clock) #1 seen = seen | {internal_reset, nmi_trap,
        start_event_xfer, fetch_vector, service_irq, resume_pulse};
    initial begin
        #20000;
        failures++;
        final_report();
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task cycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    task do_reset(input int n);
        reset = 1'h1;
        cycles(n);
        reset = 1'h0;
        seen = 6'h00;
    endtask
    task issue(input logic [31:0] w);
        instr_word = w;
        instr_valid = 1'h1;
        cycles(1);
        instr_valid = 1'h0;
        instr_word = 32'h0;
    endtask
    task enter_idle;
        do_reset(2);
        issue(`PRMC_IDLE_OPCODE);
        cycles(3);
        `CHK(idle_active, 1'h1)
    endtask
    task wake(input logic peripheral_event_transfer, input logic [3:0] lvl, input logic gie);
        irq_is_event_xfer = peripheral_event_transfer;
        irq_level = lvl;
        global_interrupt_enable = gie;
        irq_pending = 1'h1;
        cycles(1);
        irq_pending = 1'h0;
        cycles(3);
    endtask
    task final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task test_entry;
        do_reset(2);
        issue(`PRMC_IDLE_OPCODE ^ 32'h00000001);
        cycles(3);
        `CHK(cpu_halt, 1'h0)
        prev_instr_done = 1'h0;
        issue(`PRMC_IDLE_OPCODE);
        cycles(4);
        `CHK(cpu_halt, 1'h0)
        prev_instr_done = 1'h1;
        cycles(3);
        `CHK(cpu_halt, 1'h1)
        `CHK(periph_clock_gate, 1'h0)
        $display("entry test done");
    endtask
    task test_refuse;
        for (int i = 0; i < 3; i++) begin
            do_reset(2);
            bus_busy = (i == 0);
            ready_enabled = 1'h1;
            ready_seen_low = (i != 1);
            issue(`PRMC_IDLE_OPCODE);
            cycles(4);
            `CHK(cpu_halt, (i == 2))
        end
        ready_enabled = 1'h0;
        $display("refuse test done");
    endtask
    task test_cpu_irq;
        enter_idle();
        wake(1'h0, 4'h5, 1'h1);
        `CHK(seen[2:1], 2'h3)
        `CHK(cpu_halt, 1'h0)
        for (int i = 0; i < 3; i++) begin
            enter_idle();
            wake(1'h0, (i == 0) ? 4'h5 : (i == 1) ? 4'h2 : 4'h0, i != 0);
            `CHK(seen[2:0], 3'h1)
            `CHK(cpu_halt, 1'h0)
        end
        $display("interrupt test done");
    endtask
    task test_pec;
        enter_idle();
        xfer_delay = 4'h5;
        wake(1'h1, 4'h5, 1'h1);
        `CHK(cpu_halt, 1'h1)
        cycles(6);
        `CHK(seen[3], 1'h1)
        `CHK(seen[0], 1'h0)
        `CHK(idle_active, 1'h1)
        xfer_delay = 4'h0;
        wake(1'h1, 4'h5, 1'h1);
        `CHK(idle_active, 1'h1)
        wake(1'h1, 4'h1, 1'h1);
        `CHK(seen[0], 1'h1)
        `CHK(cpu_halt, 1'h0)
        $display("event transfer test done");
    endtask
    task test_nmi_wdt;
        enter_idle();
        nmi_pin = 1'h0;
        cycles(3);
        `CHK(seen[4], 1'h1)
        `CHK(cpu_halt, 1'h0)
        nmi_pin = 1'h1;
        enter_idle();
        watchdog_overflow = 1'h1;
        cycles(1);
        watchdog_overflow = 1'h0;
        cycles(2);
        `CHK(seen[5], 1'h1)
        `CHK(idle_active, 1'h0)
        $display("nmi and watchdog test done");
    endtask
    task test_down;
        do_reset(2);
        issue(`PRMC_POWER_DOWN_INSTRUCTION_OPCODE);
        cycles(3);
        `CHK(cpu_halt, 1'h0)
        nmi_pin = 1'h0;
        issue(`PRMC_POWER_DOWN_INSTRUCTION_OPCODE ^ 32'h00000100);
        cycles(3);
        `CHK(cpu_halt, 1'h0)
        prev_instr_done = 1'h0;
        issue(`PRMC_POWER_DOWN_INSTRUCTION_OPCODE);
        cycles(3);
        `CHK(down_active, 1'h0)
        prev_instr_done = 1'h1;
        cycles(3);
        `CHK({cpu_halt, periph_clock_gate}, 2'h3)
        nmi_pin = 1'h1;
        seen = 6'h00;
        watchdog_overflow = 1'h1;
        wake(1'h0, 4'h5, 1'h1);
        watchdog_overflow = 1'h0;
        `CHK(down_active, 1'h1)
        `CHK(seen, 6'h00)
        do_reset(1);
        `CHK({down_active, periph_clock_gate}, 2'h0)
        $display("power down test done");
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cycles(5);
        reset = 1'h0;
        test_entry();
        test_refuse();
        test_cpu_irq();
        test_pec();
        test_nmi_wdt();
        test_down();
        final_report();
    end
endmodule
